// File: common/fh_defines.vh
// constants for the fault history and acknowledge block
`ifndef FH_DEFINES_VH
`define FH_DEFINES_VH

`define FH_CLK_HZ          100000000
`define FH_HOLD_MS         2000
`define FH_HOLD_CYC        ((`FH_CLK_HZ / 1000) * `FH_HOLD_MS)
`define FH_DEBOUNCE_US     10000
`define FH_DEBOUNCE_CYC    ((`FH_CLK_HZ / 1000000) * `FH_DEBOUNCE_US)
`define FH_CODE_W          8
`define FH_CODE_NONE       8'h00
`define FH_CODE_DEFAULTS   8'hfe
`define FH_DEPTH           4
`define FH_PARAM_HISTORY   7'h0d
`define FH_PARAM_RESET     7'h00

`endif

// File: logic/fh_fault_history.v
// fault flag, relay, four-deep fault log and keypad browsing
`include "fh_defines.vh"

// How it works
// - fault raises error display, opens relay
// - keep four latest codes, newest first
// - power-off or stop key clears fault
// - fresh enable rising edge clears fault
// - log opens newest, up steps older
// - flashing dots count entry age
// - defaults restore leaves log intact
// - defaults restore logged with own code
// - short ok back, long ok stop
// - long ok from stop enters selection
// - relay closed while enable present and no fault
module fh_fault_history #(
    parameter HOLD_CYC     = `FH_HOLD_CYC,
    parameter DEBOUNCE_CYC = `FH_DEBOUNCE_CYC,
    parameter CODE_W       = `FH_CODE_W
) (
    // clock and reset
    input  wire              clock,
    input  wire              rst,
    // fault sources
    input  wire              faultPulse,
    input  wire [CODE_W-1:0] faultCode,
    input  wire              defaultsRestorePulse,
    // digital control pins
    input  wire              forward_enable_input,
    input  wire              reverse_enable_input,
    // keypad pins
    input  wire              keyStop,
    input  wire              keyOk,
    input  wire              keyUp,
    input  wire              keyDown,
    // outputs
    output reg               faultActive_q,
    output reg               relayClosed_q,
    output reg  [CODE_W-1:0] shownCode_q,
    output reg  [2:0]        flashDots_q,
    output reg  [1:0]        viewMode_q,
    output reg  [6:0]        paramIndex_q,
    output reg               lastDigitFlash_q
);
    // view state codes and log depth
    localparam ST_STOP   = 2'b00;
    localparam ST_SELECT = 2'b01;
    localparam ST_LOG    = 2'b10;
    localparam DEPTH     = `FH_DEPTH;

    // raw pins in one vector: 0 stop, 1 ok, 2 up, 3 down, 4 fwd, 5 rev
    wire [5:0] pinRaw = {reverse_enable_input, forward_enable_input,
                         keyDown, keyUp, keyOk, keyStop};

    // three-stage synchronisers, only stage two reads stage one
    reg  [5:0] sync1_q;
    reg  [5:0] sync2_q;
    reg  [5:0] sync3_q;
    reg  [5:0] pinLvl_q;
    wire [5:0] pinLvl_d;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a level change counts once stages two and three agree
    assign pinLvl_d = (sync2_q & sync3_q) | (pinLvl_q & (sync2_q | sync3_q));
    always @(posedge clock or posedge rst) begin
        if (rst)
            pinLvl_q <= 6'h00;
        else
            pinLvl_q <= pinLvl_d;
    end

    // debounced key levels and their one-cycle edges
    wire [3:0] keyStable;
    reg  [3:0] keyPrev_q;
    wire [3:0] keyRise = keyStable & ~keyPrev_q;
    wire [3:0] keyFall = ~keyStable & keyPrev_q;

    // per-key debounce, a level must hold for the debounce time
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : gDeb
            reg [31:0] debCnt_q;
            reg        stable_q;
            assign keyStable[k] = stable_q;
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    debCnt_q <= 32'h0;
                    stable_q <= 1'b0;
                end else if (pinLvl_q[k] == stable_q) begin
                    debCnt_q <= 32'h0; // bounce restarts the wait
                end else if (debCnt_q >= DEBOUNCE_CYC - 1) begin
                    debCnt_q <= 32'h0;
                    stable_q <= pinLvl_q[k];
                end else begin
                    debCnt_q <= debCnt_q + 32'h1;
                end
            end
        end
    endgenerate

    // previous debounced level for edge detection
    always @(posedge clock or posedge rst) begin
        if (rst)
            keyPrev_q <= 4'h0;
        else
            keyPrev_q <= keyStable;
    end

    // ok hold timer, stops once the long action has fired
    reg  [31:0] holdCnt_q;
    reg         longDone_q;
    wire        holdReached = (holdCnt_q >= HOLD_CYC - 1);
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            holdCnt_q  <= 32'h0;
            longDone_q <= 1'b0;
        end else if (!keyStable[1]) begin
            holdCnt_q  <= 32'h0; // released, armed for next press
            longDone_q <= 1'b0;
        end else if (!longDone_q) begin
            if (holdReached)
                longDone_q <= 1'b1;
            holdCnt_q <= holdCnt_q + 32'h1;
        end
    end

    // one action per press: long while held, short on early release
    reg       longPress;
    reg [3:0] shortPress;
    always @* begin
        longPress     = keyStable[1] && !longDone_q && holdReached;
        shortPress    = keyRise & 4'hd; // stop, up, down act on press
        shortPress[1] = keyFall[1] && !longDone_q;
    end

    // enable pins: level for the relay, fresh rising edge for the clear
    reg  [1:0] enPrev_q;
    wire [1:0] enLvl  = pinLvl_q[5:4];
    wire       enRise = |(enLvl & ~enPrev_q);
    wire       enAny  = |enLvl;
    always @(posedge clock or posedge rst) begin
        if (rst)
            enPrev_q <= 2'h0;
        else
            enPrev_q <= enLvl;
    end

    // a logged event is a detected fault or a manual defaults restore
    wire              logEvent = faultPulse | defaultsRestorePulse;
    wire [CODE_W-1:0] logCode  = defaultsRestorePulse ? `FH_CODE_DEFAULTS : faultCode;

    // fault log, entry 0 newest; a defaults restore only adds an entry
    reg [CODE_W-1:0] logMem_q [0:DEPTH-1];
    integer          i;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            for (i = 0; i < DEPTH; i = i + 1)
                logMem_q[i] <= `FH_CODE_NONE; // power-off empties the log
        end else if (logEvent) begin
            for (i = DEPTH - 1; i > 0; i = i - 1)
                logMem_q[i] <= logMem_q[i-1];
            logMem_q[0] <= logCode;
        end
    end

    // number of entries held, saturates at the log depth
    reg [2:0] logFill_q;
    always @(posedge clock or posedge rst) begin
        if (rst)
            logFill_q <= 3'h0;
        else if (logEvent && logFill_q != 3'h4)
            logFill_q <= logFill_q + 3'h1;
    end

    // active fault: a new event wins over a clear in the same cycle
    reg faultActive_d;
    always @* begin
        faultActive_d = faultActive_q;
        if (logEvent)
            faultActive_d = 1'b1;
        else if (shortPress[0] || enRise)
            faultActive_d = 1'b0;
    end
    always @(posedge clock or posedge rst) begin
        if (rst)
            faultActive_q <= 1'b0;
        else
            faultActive_q <= faultActive_d;
    end

    // run relay closed while an enable is present and no fault stands
    always @(posedge clock or posedge rst) begin
        if (rst)
            relayClosed_q <= 1'b0;
        else
            relayClosed_q <= enAny && !faultActive_d;
    end

    // keypad view next state: stop, parameter selection, log browsing
    reg [1:0] viewMode_d;
    reg [6:0] paramIndex_d;
    reg [1:0] logPos_q;
    reg [1:0] logPos_d;
    reg       lastDigitFlash_d;
    wire      logOlder = ({1'b0, logPos_q} + 3'h1) < logFill_q;
    always @* begin
        viewMode_d       = viewMode_q;
        paramIndex_d     = paramIndex_q;
        logPos_d         = logPos_q;
        lastDigitFlash_d = lastDigitFlash_q;
        case (viewMode_q)
            ST_STOP: begin
                if (longPress) begin
                    viewMode_d       = ST_SELECT;
                    lastDigitFlash_d = 1'b1;
                end
            end
            ST_SELECT: begin
                if (longPress) begin
                    viewMode_d       = ST_STOP;
                    lastDigitFlash_d = 1'b0;
                end else if (shortPress[2]) begin
                    paramIndex_d = paramIndex_q + 7'h1;
                end else if (shortPress[3]) begin
                    paramIndex_d = paramIndex_q - 7'h1;
                end else if (shortPress[1] && paramIndex_q == `FH_PARAM_HISTORY) begin
                    viewMode_d       = ST_LOG;
                    logPos_d         = 2'h0;
                    lastDigitFlash_d = 1'b0;
                end
            end
            ST_LOG: begin
                if (longPress) begin
                    viewMode_d = ST_STOP;
                end else if (shortPress[1]) begin
                    viewMode_d       = ST_SELECT;
                    lastDigitFlash_d = 1'b1;
                end else if (shortPress[2] && logOlder) begin
                    logPos_d = logPos_q + 2'h1;
                end
            end
            default: begin
                viewMode_d       = ST_STOP;
                lastDigitFlash_d = 1'b0;
            end
        endcase
    end

    // view registers
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            viewMode_q       <= ST_STOP;
            paramIndex_q     <= `FH_PARAM_RESET;
            logPos_q         <= 2'h0;
            lastDigitFlash_q <= 1'b0;
        end else begin
            viewMode_q       <= viewMode_d;
            paramIndex_q     <= paramIndex_d;
            logPos_q         <= logPos_d;
            lastDigitFlash_q <= lastDigitFlash_d;
        end
    end

    // age dots: none for the newest, then one, two and three
    function [2:0] ageDots(input [1:0] pos);
        case (pos)
            2'h0:    ageDots = 3'h0;
            2'h1:    ageDots = 3'h1;
            2'h2:    ageDots = 3'h3;
            default: ageDots = 3'h7;
        endcase
    endfunction

    // shown code: log entry in log view, else the newest active fault
    always @(posedge clock or posedge rst) begin
        if (rst)
            shownCode_q <= `FH_CODE_NONE;
        else if (viewMode_q == ST_LOG)
            shownCode_q <= logMem_q[logPos_q];
        else if (faultActive_q)
            shownCode_q <= logMem_q[0];
        else
            shownCode_q <= `FH_CODE_NONE;
    end

    // age dots only in log view
    always @(posedge clock or posedge rst) begin
        if (rst)
            flashDots_q <= 3'h0;
        else if (viewMode_q == ST_LOG)
            flashDots_q <= ageDots(logPos_q);
        else
            flashDots_q <= 3'h0;
    end
endmodule

// File: bench/fh_fault_history_chk.sv
// assertions on the fault history block ports
module fh_fault_history_chk (
    // clock and reset
    input logic       clock,
    input logic       rst,
    // fault sources
    input logic       faultPulse,
    input logic       defaultsRestorePulse,
    // status
    input logic       faultActive_q,
    input logic       relayClosed_q,
    input logic [7:0] shownCode_q,
    input logic [2:0] flashDots_q,
    input logic [1:0] viewMode_q,
    input logic       lastDigitFlash_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // fault flag, relay and log display
    property p_set; faultPulse |=> faultActive_q && !relayClosed_q; endproperty
    a_set: assert property (p_set) else $error("fault not set");
    property p_rise; $rose(faultActive_q) |-> $past(faultPulse) || $past(defaultsRestorePulse); endproperty
    a_rise: assert property (p_rise) else $error("fault without cause");
    property p_clr; $fell(faultActive_q) |-> !$past(faultPulse) && !$past(defaultsRestorePulse); endproperty
    a_clr: assert property (p_clr) else $error("clear beat new fault");
    property p_dflt; defaultsRestorePulse ##1 !faultPulse && viewMode_q == 2'h0 |=> shownCode_q == 8'hfe; endproperty
    a_dflt: assert property (p_dflt) else $error("restore not logged");
    property p_relay; relayClosed_q |-> !faultActive_q; endproperty
    a_relay: assert property (p_relay) else $error("relay closed on fault");
    property p_dots; viewMode_q == 2'h2 |-> flashDots_q inside {3'h0, 3'h1, 3'h3, 3'h7}; endproperty
    a_dots: assert property (p_dots) else $error("bad dot pattern");
    property p_open; $changed(viewMode_q) && viewMode_q == 2'h2 |=> flashDots_q == 3'h0; endproperty
    a_open: assert property (p_open) else $error("log not opened at newest");
    property p_flash; viewMode_q == 2'h1 |-> lastDigitFlash_q; endproperty
    a_flash: assert property (p_flash) else $error("no digit flash");
endmodule
bind fh_fault_history fh_fault_history_chk i_fh_fault_history_chk (
    .clock(clock), .rst(rst), .faultPulse(faultPulse), .defaultsRestorePulse(defaultsRestorePulse),
    .faultActive_q(faultActive_q), .relayClosed_q(relayClosed_q), .shownCode_q(shownCode_q),
    .flashDots_q(flashDots_q), .viewMode_q(viewMode_q), .lastDigitFlash_q(lastDigitFlash_q));

// File: bench/fh_keypad_model.sv
// keypad and enable pin model facing the fault block
module fh_keypad_model (
    // clock
    input  logic       clock,
    // keys stop, ok, up, down and enable pins
    output logic [3:0] keys,
    output logic       fwdEn,
    output logic       revEn
);
    timeunit 1ns;
    timeprecision 1ns;
    // all lines idle at start
    initial {keys, fwdEn, revEn} = 6'h00;
    // hold a key n cycles, then idle past the debounce
    task automatic press(input int k, input int n);
        keys[k] = 1'b1;
        repeat (n) @(negedge clock);
        keys[k] = 1'b0;
        repeat (12) @(negedge clock);
    endtask
    // set enable pins, wait out the synchroniser
    task automatic drive(input logic f, input logic r);
        fwdEn = f;
        revEn = r;
        repeat (10) @(negedge clock);
    endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the fault history block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0, rst = 1'b1, fp = 1'b0, rs = 1'b0;
    logic       fwdEn, revEn, faultOn, relay, flash;
    logic [7:0] code = 8'h00, shown;
    logic [3:0] keys;
    logic [2:0] dots;
    logic [1:0] mode;
    logic [6:0] idx;
    int         error_cnt = 0, n_compared = 0, cycles = 0;
    always #5 clock = ~clock;
    // cut a hung run short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    fh_fault_history #(.HOLD_CYC(20), .DEBOUNCE_CYC(4)) i_fh_fault_history (
        .clock(clock), .rst(rst), .faultPulse(fp), .faultCode(code), .defaultsRestorePulse(rs),
        .forward_enable_input(fwdEn), .reverse_enable_input(revEn), .keyStop(keys[0]),
        .keyOk(keys[1]), .keyUp(keys[2]), .keyDown(keys[3]), .faultActive_q(faultOn),
        .relayClosed_q(relay), .shownCode_q(shown), .flashDots_q(dots), .viewMode_q(mode),
        .paramIndex_q(idx), .lastDigitFlash_q(flash));
    fh_keypad_model i_fh_keypad_model (.clock(clock), .keys(keys), .fwdEn(fwdEn), .revEn(revEn));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic key(input int k, input int n);
        i_fh_keypad_model.press(k, n);
    endtask
    // one-cycle fault or restore pulse
    task automatic pulse(input logic [7:0] c, input logic r);
        code = c;
        fp = !r;
        rs = r;
        @(negedge clock);
        fp = 1'b0;
        rs = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    // long ok, step to the log parameter, short ok
    task automatic openLog();
        key(1, 40);
        check(flash, 1'b1);
        for (int i = 0; i < 20 && idx !== 7'h0d; i++) key(2, 12);
        key(2, 12);
        check(idx, 8'h0e);
        key(3, 12);
        check(idx, 8'h0d);
        key(1, 12);
        check(mode, 2'h2);
    endtask
    // five faults overflow the log, then browse it
    task automatic scLog();
        logic [7:0] e[5] = '{8'h55, 8'h44, 8'h33, 8'h22, 8'h22};
        logic [2:0] d[5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h7};
        for (int i = 1; i <= 5; i++) pulse(8'(i * 17), 1'b0);
        check(faultOn, 1'b1);
        check(relay, 1'b0);
        openLog();
        for (int i = 0; i < 5; i++) begin
            check(shown, e[i]);
            check(dots, d[i]);
            key(2, 12);
        end
        key(1, 12);
        check(mode, 2'h1);
        key(1, 12);
        key(1, 40);
        check(mode, 2'h0);
    endtask
    // stop key and fresh enable edges clear the fault
    task automatic scClear();
        key(0, 12);
        check(faultOn, 1'b0);
        i_fh_keypad_model.drive(1'b1, 1'b0);
        check(relay, 1'b1);
        pulse(8'h66, 1'b0);
        check(faultOn, 1'b1);
        check(relay, 1'b0);
        i_fh_keypad_model.drive(1'b1, 1'b1);
        check(faultOn, 1'b0);
        i_fh_keypad_model.drive(1'b0, 1'b0);
        check(relay, 1'b0);
        pulse(8'h77, 1'b0);
        i_fh_keypad_model.drive(1'b1, 1'b0);
        check(faultOn, 1'b0);
        i_fh_keypad_model.drive(1'b0, 1'b0);
    endtask
    // restore logs its own code and keeps older entries
    task automatic scRestore();
        pulse(8'h00, 1'b1);
        check(faultOn, 1'b1);
        openLog();
        check(shown, 8'hfe);
        key(2, 12);
        check(shown, 8'h77);
    endtask
    // power removal in mid-run clears the fault and the view
    task automatic scPower();
        pulse(8'h88, 1'b0);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        check(faultOn, 1'b0);
        check(shown, 8'h00);
        check(mode, 2'h0);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        scLog();
        scClear();
        scRestore();
        scPower();
        final_report();
    end
endmodule
